// ===== core/adsc_pkg.sv
// Shared constants and types of the dual converter sequencing control.
package adsc_pkg;
  localparam int ADSC_NMOD = 2;
  localparam int ADSC_NIN = 32;
  // ===========================================================
  // Register offsets (word index; bit 5 of the link address picks the module).
  localparam logic [4:0] OFS_CON1 = 5'h00;
  localparam logic [4:0] OFS_CON2 = 5'h01;
  localparam logic [4:0] OFS_CHSEL = 5'h02;
  localparam logic [4:0] OFS_SCANL = 5'h03;
  localparam logic [4:0] OFS_SCANH = 5'h04;
  localparam logic [4:0] OFS_PCFGL = 5'h05;
  localparam logic [4:0] OFS_PCFGH = 5'h06;
  localparam logic [4:0] OFS_STAT = 5'h07;
  localparam logic [4:0] OFS_RES = 5'h10;
  // ===========================================================
  // Field positions.
  localparam int B_ON = 15;
  localparam int B_DBO = 12;
  localparam int B_RES = 10;
  localparam int B_FMT = 8;
  localparam int B_TRG = 5;
  localparam int B_AUTO = 2;
  localparam int B_SAMPLE_CONTROL = 1;
  localparam int B_DONE = 0;
  localparam int B_SCAN = 10;
  localparam int B_CHPS = 8;
  localparam int B_PIC = 2;
  localparam int B_IRQ = 0;
  localparam int B_PTR = 4;
  localparam int B_DSZ = 8;
  localparam logic [15:0] CON1_WMASK = 16'hb7ef;
  localparam logic [15:0] CON2_WMASK = 16'he73f;
  localparam logic [2:0] TRG_MANUAL = 3'h0;
  localparam logic [2:0] TRG_AUTO = 3'h7;
  // ===========================================================
  // Timing.
  localparam int CLK_NS = 40;
  localparam int AUTO_SAMPLE_NS = 1000;
  localparam logic [7:0] SAMPLE_CONTROL_CYC = 8'((AUTO_SAMPLE_NS + CLK_NS - 1) / CLK_NS);
  // ===========================================================
  // States.
  typedef enum logic [2:0] {CV_IDLE = 3'b001, CV_SAMPLE_CONTROL = 3'b010, CV_CONV = 3'b100} adsc_cv_t;
  typedef enum logic [2:0] {HS_IDLE = 3'b001, HS_APB = 3'b010, HS_DMA = 3'b100} adsc_hs_t;
endpackage : adsc_pkg

// ===== core/adsc_link_if.sv
// Link between the register/DMA host end and the converter control end.
`timescale 1ns/1ps
interface adsc_link_if;
  logic req;
  logic wr;
  logic [5:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic [1:0] dma_req;
  logic [1:0][9:0] dma_addr;
  logic [1:0] irq_flag;
  modport dev (input req, wr, addr, wdata, output ack, rdata, dma_req, dma_addr, irq_flag);
  modport host (output req, wr, addr, wdata, input ack, rdata, dma_req, dma_addr, irq_flag);
endinterface : adsc_link_if

// ===== core/adsc_dev.sv
// Converter sequencing control: registers, sample/convert handshake, results, DMA addresses.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module adsc_dev
  import adsc_pkg::*;
#(
  parameter bit HAS_DMA = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Register and DMA link.
  adsc_link_if.dev lk,
  // Analog core.
  output logic [1:0][3:0] sh_en,
  output logic [1:0] conv_start,
  output logic [1:0][4:0] ch0_sel,
  input wire logic [1:0] conv_done,
  input wire logic [1:0][11:0] conv_data,
  input wire logic [1:0] trig_pin,
  // Shared pins.
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_digital_en,
  output logic [31:0] pin_digital_in
);
  typedef struct packed {
    adsc_cv_t st;
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] chsel;
    logic [15:0] scanl;
    logic [15:0] scanh;
    logic [15:0] pcfgl;
    logic [15:0] pcfgh;
    logic [2:0] dsz;
    logic irq;
    logic [3:0] ptr;
    logic [3:0] ops;
    logic [2:0] left;
    logic [4:0] ain;
    logic [4:0] sel;
    logic [7:0] cnt;
    logic [5:0] didx;
    logic [15:0][15:0] res;
    logic [3:0] sh;
    logic start;
    logic dreq;
    logic [9:0] daddr;
    logic [2:0] trg;
  } adsc_mod_t;

  typedef struct packed {
    adsc_mod_t [1:0] m;
    logic ack;
    logic [15:0] rdata;
    logic [31:0] ds1;
    logic [31:0] ds2;
    logic [31:0] den;
    logic [31:0] din;
  } adsc_dev_t;

  adsc_dev_t s;
  adsc_dev_t next_s;

  // ===========================================================
  // Helpers.
  function automatic logic [15:0] fmt(input logic [11:0] d, input logic b12,
                                      input logic [1:0] f);
    logic [15:0] r;
    r = '0;
    if (b12) begin
      unique case (f)
        2'h0: r = {4'h0, d};
        2'h1: r = {{5{~d[11]}}, d[10:0]};
        2'h2: r = {d, 4'h0};
        2'h3: r = {~d[11], d[10:0], 4'h0};
      endcase
    end else begin
      unique case (f)
        2'h0: r = {6'h00, d[9:0]};
        2'h1: r = {{7{~d[9]}}, d[8:0]};
        2'h2: r = {d[9:0], 6'h00};
        2'h3: r = {~d[9], d[8:0], 6'h00};
      endcase
    end
    return r;
  endfunction : fmt

  // Channels converted per operation; twelve-bit mode forces a single one.
  function automatic logic [2:0] nch(input adsc_mod_t c);
    if (c.con1[B_RES]) return 3'h1;
    if (c.con2[B_CHPS+1]) return 3'h4;
    return c.con2[B_CHPS] ? 3'h2 : 3'h1;
  endfunction : nch

  // Next enabled input above cur, wrapping to the lowest; first restarts the list.
  function automatic logic [4:0] next_in(input logic [31:0] l, input logic [4:0] cur,
                                         input logic first);
    logic [4:0] r;
    logic [4:0] lo;
    logic hit;
    r = cur;
    lo = cur;
    hit = 1'b0;
    for (int i = ADSC_NIN - 1; i >= 0; i--) begin
      if (l[i]) begin
        lo = 5'(i);
        if (!first && 5'(i) > cur) begin
          r = 5'(i);
          hit = 1'b1;
        end
      end
    end
    return hit ? r : lo;
  endfunction : next_in

  function automatic logic [15:0] reg_rd(input adsc_mod_t c, input logic [4:0] a);
    logic [15:0] r;
    r = '0;
    if (a[4]) begin
      r = c.res[HAS_DMA ? 4'h0 : a[3:0]];
    end else begin
      unique case (a)
        OFS_CON1: r = c.con1;
        OFS_CON2: r = c.con1[B_RES] ? (c.con2 & ~(16'h3 << B_CHPS)) : c.con2;
        OFS_CHSEL: r = c.chsel;
        OFS_SCANL: r = c.scanl;
        OFS_SCANH: r = c.scanh;
        OFS_PCFGL: r = c.pcfgl;
        OFS_PCFGH: r = c.pcfgh;
        OFS_STAT: r = {5'h00, c.dsz, c.ptr, 3'h0, c.irq};
        default: r = '0;
      endcase
    end
    return r;
  endfunction : reg_rd

  // One cycle of one module: register write, then the sequencer on top of it.
  function automatic adsc_mod_t step(input adsc_mod_t c, input logic we, input logic [4:0] a,
                                     input logic [15:0] wd, input logic cd,
                                     input logic [11:0] cdat, input logic tp);
    adsc_mod_t m;
    logic go;
    logic [3:0] slot;
    logic [5:0] dmask;
    logic [31:0] list;
    m = c;
    go = 1'b0;
    m.start = 1'b0;
    m.dreq = 1'b0;
    m.trg = {c.trg[1:0], tp};
    dmask = 6'((7'h1 << c.dsz) - 7'h1);
    list = {c.scanh, c.scanl};
    if (we) begin
      unique case (a)
        OFS_CON1: begin
          m.con1 = wd & CON1_WMASK;
          if (c.con1[B_ON]) m.con1[B_RES] = c.con1[B_RES];
          m.con1[B_DONE] = c.con1[B_DONE] & wd[B_DONE];
        end
        OFS_CON2: m.con2 = wd & CON2_WMASK;
        OFS_CHSEL: m.chsel = {11'h000, wd[4:0]};
        OFS_SCANL: m.scanl = wd;
        OFS_SCANH: m.scanh = wd;
        OFS_PCFGL: m.pcfgl = wd;
        OFS_PCFGH: m.pcfgh = wd;
        OFS_STAT: begin
          m.irq = c.irq & wd[B_IRQ];
          m.dsz = wd[B_DSZ+:3];
        end
        default: ;
      endcase
    end
    if (!m.con1[B_ON]) begin
      m.st = CV_IDLE;
      m.con1[B_SAMPLE_CONTROL] = 1'b0;
      m.ops = '0;
      m.ptr = '0;
      m.sh = '0;
      m.ain = next_in(list, c.ain, 1'b1);
    end else begin
      unique case (c.st)
        CV_IDLE: begin
          if (m.con1[B_AUTO]) m.con1[B_SAMPLE_CONTROL] = 1'b1;
          if (m.con1[B_SAMPLE_CONTROL]) begin
            m.st = CV_SAMPLE_CONTROL;
            m.cnt = '0;
          end
        end
        CV_SAMPLE_CONTROL: begin
          m.sh = 4'((5'h1 << nch(c)) - 5'h1);
          m.cnt = c.cnt + 8'h1;
          if (c.con1[B_TRG+:3] == TRG_MANUAL) go = !m.con1[B_SAMPLE_CONTROL];
          else if (c.con1[B_TRG+:3] == TRG_AUTO) go = c.cnt >= SAMPLE_CONTROL_CYC - 8'h1;
          else go = c.trg[1] & !c.trg[2];
          if (go) begin
            m.con1[B_SAMPLE_CONTROL] = 1'b0;
            m.con1[B_DONE] = 1'b0;
            m.start = 1'b1;
            m.sh = '0;
            m.left = nch(c);
            m.st = CV_CONV;
          end
        end
        CV_CONV: begin
          if (cd) begin
            // With DMA the single buffer is overwritten by every result.
            slot = HAS_DMA ? 4'h0 : c.ptr;
            m.res[slot] = fmt(cdat, c.con1[B_RES], c.con1[B_FMT+:2]);
            if (c.con1[B_DBO]) m.daddr = {6'h00, c.ptr};
            else m.daddr = 10'({5'h00, c.ain} << c.dsz) | {4'h0, c.didx & dmask};
            m.ptr = c.ptr + 4'h1;
            m.left = c.left - 3'h1;
            if (c.left == 3'h1) begin
              m.con1[B_DONE] = 1'b1;
              m.st = CV_IDLE;
              if (c.ops == c.con2[B_PIC+:4]) begin
                m.ops = '0;
                m.ptr = '0;
                m.irq = 1'b1;
                m.dreq = 1'b1;
                m.didx = (c.didx + 6'h1) & dmask;
                m.ain = next_in(list, c.ain, 1'b1);
              end else begin
                m.ops = c.ops + 4'h1;
                m.ain = next_in(list, c.ain, 1'b0);
              end
            end
          end
        end
      endcase
    end
    m.sel = m.con2[B_SCAN] ? m.ain : m.chsel[4:0];
    return m;
  endfunction : step

  // ===========================================================
  // State update.
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.ds1 = pin_in;
    next_s.ds2 = s.ds1;
    next_s.den = {s.m[0].pcfgh, s.m[0].pcfgl} & {s.m[1].pcfgh, s.m[1].pcfgl};
    next_s.din = s.ds2 & s.den;
    if (lk.req && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = reg_rd(s.m[lk.addr[5]], lk.addr[4:0]);
    end
    for (int k = 0; k < ADSC_NMOD; k++) begin
      next_s.m[k] = step(s.m[k], lk.req && !s.ack && lk.wr && lk.addr[5] == 1'(k),
                         lk.addr[4:0], lk.wdata, conv_done[k], conv_data[k], trig_pin[k]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.m[0].st <= CV_IDLE;
      s.m[1].st <= CV_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ===========================================================
  // Outputs.
  assign lk.ack = s.ack;
  assign lk.rdata = s.rdata;
  assign pin_digital_en = s.den;
  assign pin_digital_in = s.din;
  for (genvar k = 0; k < ADSC_NMOD; k++) begin : g_out
    assign sh_en[k] = s.m[k].sh;
    assign conv_start[k] = s.m[k].start;
    assign ch0_sel[k] = s.m[k].sel;
    assign lk.dma_req[k] = s.m[k].dreq;
    assign lk.dma_addr[k] = s.m[k].daddr;
    assign lk.irq_flag[k] = s.m[k].irq;
  end
endmodule : adsc_dev

// ===== core/adsc_host.sv
// Host end: APB slave for software and DMA channel that drains converter results.
`timescale 1ns/1ps
module adsc_host
  import adsc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // DMA write port and interrupt flags.
  output logic dma_valid,
  output logic dma_chan,
  output logic [9:0] dma_waddr,
  output logic [15:0] dma_wdata,
  output logic [1:0] irq,
  // Link to the converter control.
  adsc_link_if.host lk
);
  typedef struct packed {
    adsc_hs_t st;
    logic req;
    logic wr;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic pready;
    logic [31:0] prdata;
    logic [1:0] pend;
    logic [1:0][9:0] dl;
    logic chan;
    logic dvalid;
    logic dchan;
    logic [9:0] daddr;
    logic [15:0] ddata;
    logic [1:0] irq;
  } adsc_host_t;

  adsc_host_t s;
  adsc_host_t next_s;

  // ===========================================================
  // APB has priority; pending DMA reads go out when software is quiet.
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.dvalid = 1'b0;
    next_s.irq = lk.irq_flag;
    for (int k = 0; k < ADSC_NMOD; k++) begin
      if (lk.dma_req[k]) begin
        next_s.pend[k] = 1'b1;
        next_s.dl[k] = lk.dma_addr[k];
      end
    end
    unique case (s.st)
      HS_IDLE: begin
        // A setup that arrives while a DMA read is busy is still taken afterwards.
        if (psel && !s.pready) begin
          next_s.req = 1'b1;
          next_s.wr = pwrite;
          next_s.addr = paddr[7:2];
          next_s.wdata = pwdata[15:0];
          next_s.st = HS_APB;
        end else if (|s.pend) begin
          // Drain at once, since the next result overwrites the single buffer.
          // A request arriving during the read stays pending, so no result is lost.
          next_s.chan = !s.pend[0];
          next_s.pend[!s.pend[0]] = lk.dma_req[!s.pend[0]];
          next_s.daddr = s.dl[!s.pend[0]];
          next_s.req = 1'b1;
          next_s.wr = 1'b0;
          next_s.addr = {!s.pend[0], OFS_RES};
          next_s.st = HS_DMA;
        end
      end
      HS_APB: begin
        if (lk.ack) begin
          next_s.req = 1'b0;
          next_s.pready = 1'b1;
          next_s.prdata = {16'h0000, lk.rdata};
          next_s.st = HS_IDLE;
        end
      end
      HS_DMA: begin
        if (lk.ack) begin
          next_s.req = 1'b0;
          next_s.dvalid = 1'b1;
          next_s.dchan = s.chan;
          next_s.ddata = lk.rdata;
          next_s.st = HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.st <= HS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ===========================================================
  // Outputs.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = 1'b0;
  assign dma_valid = s.dvalid;
  assign dma_chan = s.dchan;
  assign dma_waddr = s.daddr;
  assign dma_wdata = s.ddata;
  assign irq = s.irq;
  assign lk.req = s.req;
  assign lk.wr = s.wr;
  assign lk.addr = s.addr;
  assign lk.wdata = s.wdata;
endmodule : adsc_host

// ===== sim/adsc_link_monitor.sv
// Protocol checker for the link between the host end and the converter control end.
`timescale 1ns/1ps
module adsc_link_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Link signals.
  input wire logic req,
  input wire logic wr,
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic [1:0] dma_req,
  input wire logic [1:0][9:0] dma_addr,
  input wire logic [1:0] irq_flag
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Assertions.
  ack_answer_a:
    assert property ($rose(req) |=> ack) else $error("link request not answered");
  ack_single_a:
    assert property (ack |=> !ack) else $error("link ack too long");
  ack_cause_a:
    assert property (ack |-> $past(req)) else $error("link ack without request");
  req_hold_a:
    assert property (req && !ack |=> req) else $error("link request dropped early");
  req_drop_a:
    assert property (ack |=> !req) else $error("link request held after ack");
  dma_pulse_a:
    assert property (dma_req != 2'h0 |=> (dma_req & $past(dma_req)) == 2'h0)
      else $error("dma request too long");
  dma_flag_a:
    assert property (dma_req[0] |-> ##[0:1] irq_flag[0]) else $error("dma request without flag");
  flag_dma_a:
    assert property ($rose(irq_flag[1]) |-> $past(dma_req[1]) or ##[0:1] dma_req[1])
      else $error("flag set without dma request");
  flag_clear_a:
    assert property ($fell(irq_flag[0]) |-> (wr && ack) || $past(wr && ack))
      else $error("flag cleared without write");
  // ==========================================================
  // Coverage of the main traffic.
  cover property (ack && wr);
  cover property (ack && !wr && rdata != 16'h0000);
  cover property (dma_req[0]);
  cover property (dma_req[1]);
endmodule : adsc_link_monitor

// ===== sim/testbench.sv
// Self-checking bench: APB software, converter core and pins around both ends.
`timescale 1ns/1ps
module testbench
  import adsc_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv, pin_digital_en, pin_digital_in;
  logic pready, pslverr, dma_valid, dma_chan, last_ch, go;
  logic [9:0] dma_waddr, last_wa;
  logic [15:0] dma_wdata, last_dma, e;
  logic [1:0] irq, conv_start;
  logic [1:0][3:0] sh_en;
  logic [1:0][4:0] ch0_sel;
  logic [1:0] conv_done = 2'h0;
  logic [1:0][11:0] conv_data = '0;
  logic [1:0] trig_pin = 2'h0;
  logic [31:0] pin_in = 32'hffffffff;
  logic [11:0] seq [2] = '{12'h8a5, 12'h35c};
  int left [2] = '{0, 0};
  int wt [2] = '{0, 0};
  int nsh [2] = '{1, 1};
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_dma = 0;
  int n_cv = 0;
  int k, c0;
  adsc_link_if lk ();
  adsc_host adsc_host_inst (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_valid(dma_valid), .dma_chan(dma_chan), .dma_waddr(dma_waddr),
    .dma_wdata(dma_wdata), .irq(irq), .lk(lk.host));
  adsc_dev adsc_dev_inst (.clk(clk), .arst_n(arst_n), .lk(lk.dev), .sh_en(sh_en),
    .conv_start(conv_start), .ch0_sel(ch0_sel), .conv_done(conv_done), .conv_data(conv_data),
    .trig_pin(trig_pin), .pin_in(pin_in), .pin_digital_en(pin_digital_en),
    .pin_digital_in(pin_digital_in));
  adsc_link_monitor adsc_link_monitor_inst (.clk(clk), .arst_n(arst_n), .req(lk.req),
    .wr(lk.wr), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata),
    .dma_req(lk.dma_req), .dma_addr(lk.dma_addr), .irq_flag(lk.irq_flag));
  always #20 clk = ~clk;
  // ==========================================================
  // Converter core: one result per enabled sample/hold, spaced so that done can be polled low.
  always @(posedge clk) begin
    for (int m = 0; m < 2; m++) begin
      if (sh_en[m] != 4'h0) nsh[m] = $countones(sh_en[m]);
      go = left[m] > 0 && wt[m] == 0 && conv_start[m] !== 1'b1;
      conv_done[m] <= go;
      conv_data[m] <= go ? seq[m] : ~conv_data[m];
      if (conv_start[m] === 1'b1) begin
        left[m] = nsh[m];
        wt[m] = 12;
      end else if (go) begin
        left[m] = left[m] - 1;
        wt[m] = 1;
        seq[m] = seq[m] + 12'h3c7;
      end else if (wt[m] > 0) begin
        wt[m] = wt[m] - 1;
      end
    end
    if (conv_done[1] === 1'b1) n_cv <= n_cv + 1;
    if (dma_valid === 1'b1) begin
      n_dma <= n_dma + 1;
      last_dma <= dma_wdata;
      last_wa <= dma_waddr;
      last_ch <= dma_chan;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  // ==========================================================
  // Tasks.
  task automatic end_sim;
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] got, input logic [31:0] x);
    n_compared++;
    if (got !== x) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, x);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic m, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {m, a, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic m, input logic [4:0] a, input logic [15:0] d);
    apb(1'b1, m, a, d);
  endtask : wr
  task automatic rd_chk(input logic m, input logic [4:0] a, input logic [31:0] x);
    apb(1'b0, m, a, 16'h0000);
    cmp(rv, x);
  endtask : rd_chk
  task automatic wait_done(input logic m);
    rv = 32'h0;
    while (rv[B_DONE] !== 1'b1) apb(1'b0, m, OFS_CON1, 16'h0000);
  endtask : wait_done
  function automatic logic [15:0] fmt12(input logic [1:0] f, input logic [11:0] d);
    case (f)
      2'h0: return {4'h0, d};
      2'h1: return {{5{~d[11]}}, d[10:0]};
      2'h2: return {d, 4'h0};
      default: return {~d[11], d[10:0], 4'h0};
    endcase
  endfunction : fmt12
  // ==========================================================
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(1'b0, OFS_CON1, 32'h0);
    wr(1'b1, OFS_CON2, 16'hffff);
    rd_chk(1'b1, OFS_CON2, {16'h0, CON2_WMASK});
    rd_chk(1'b0, OFS_CON2, 32'h0);
    wr(1'b1, OFS_CON2, 16'h0000);
    wr(1'b0, 5'h08, 16'hffff);
    rd_chk(1'b0, 5'h08, 32'h0);
    wr(1'b0, OFS_PCFGL, 16'h00ff);
    wr(1'b1, OFS_PCFGL, 16'h0f0f);
    wr(1'b0, OFS_PCFGH, 16'hffff);
    wr(1'b1, OFS_PCFGH, 16'h8001);
    rd_chk(1'b1, OFS_PCFGL, 32'h0f0f);
    cmp(pin_digital_en, 32'h8001000f);
    cmp(pin_digital_in, 32'h8001000f);
    pin_in <= 32'h7ffffff0;
    rd_chk(1'b1, OFS_PCFGH, 32'h8001);
    cmp(pin_digital_in, 32'h00010000);
    // Resolution is frozen while the module runs.
    wr(1'b0, OFS_CON1, 16'h8000);
    wr(1'b0, OFS_CON1, 16'h8400);
    rd_chk(1'b0, OFS_CON1, 32'h8000);
    wr(1'b0, OFS_CON1, 16'h0000);
    wr(1'b0, OFS_CON1, 16'h0400);
    wr(1'b0, OFS_CON2, 16'h0300);
    rd_chk(1'b0, OFS_CON2, 32'h0);
    rd_chk(1'b0, OFS_CON1, 32'h0400);
    e = {4'h0, seq[0]};
    k = n_dma;
    wr(1'b0, OFS_CON1, 16'h8400);
    wr(1'b0, OFS_CON1, 16'h8402);
    cmp(sh_en[0], 4'h1);
    wr(1'b0, OFS_CON1, 16'h8401);
    wait_done(1'b0);
    cmp(rv, 32'h8401);
    while (n_dma == k) @(posedge clk);
    cmp(last_dma, e);
    wr(1'b0, OFS_CON1, 16'h8403);
    rd_chk(1'b0, OFS_CON1, 32'h8403);
    wr(1'b0, OFS_CON1, 16'h8401);
    rd_chk(1'b0, OFS_CON1, 32'h8400);
    wait_done(1'b0);
    // Ten-bit mode samples four inputs at once.
    wr(1'b0, OFS_CON1, 16'h0000);
    wr(1'b0, OFS_CON1, 16'h8000);
    wr(1'b0, OFS_CON1, 16'h8002);
    cmp(sh_en[0], 4'hf);
    // The fourth result of the operation is the one left for the DMA read.
    e = {6'h00, 10'(seq[0] + 12'hb55)};
    k = n_dma;
    wr(1'b0, OFS_CON1, 16'h8000);
    wait_done(1'b0);
    while (n_dma == k) @(posedge clk);
    cmp(last_dma, e);
    rd_chk(1'b0, OFS_CON2, 32'h0300);
    // Every result format on the second module, read by DMA and through an aliased buffer.
    wr(1'b1, OFS_CON1, 16'h0400);
    for (int f = 0; f < 4; f++) begin
      e = fmt12(2'(f), seq[1]);
      k = n_dma;
      wr(1'b1, OFS_STAT, 16'h0000);
      wr(1'b1, OFS_CON1, 16'h8402 | 16'(f << 8));
      wr(1'b1, OFS_CON1, 16'h8400 | 16'(f << 8));
      wait_done(1'b1);
      while (n_dma == k) @(posedge clk);
      cmp(last_dma, e);
      cmp(last_ch, 1'b1);
      rd_chk(1'b1, OFS_RES + 5'(f), {16'h0, e});
    end
    // Scan of inputs 1 and 31 restarts after each block of two operations.
    wr(1'b0, OFS_CON1, 16'h0400);
    wr(1'b0, OFS_CON2, 16'h0404);
    wr(1'b0, OFS_SCANL, 16'h0002);
    wr(1'b0, OFS_SCANH, 16'h8000);
    wr(1'b0, OFS_CON1, 16'h8400);
    for (int i = 0; i < 3; i++) begin
      wr(1'b0, OFS_STAT, 16'h0000);
      wr(1'b0, OFS_CON1, 16'h8402);
      cmp(ch0_sel[0], (i == 1) ? 5'h1f : 5'h01);
      wr(1'b0, OFS_CON1, 16'h8400);
      wait_done(1'b0);
      apb(1'b0, 1'b0, OFS_STAT, 16'h0000);
      cmp(rv[B_IRQ], i == 1);
      cmp(irq[0], i == 1);
    end
    cmp(last_wa, 32'd31);
    // Edge trigger source: sampling waits for the pin, then hardware clears the sample bit.
    wr(1'b0, OFS_CON1, 16'h8422);
    rd_chk(1'b0, OFS_CON1, 32'h8422);
    trig_pin[0] <= 1'b1;
    wait_done(1'b0);
    cmp(rv, 32'h8421);
    // Auto sampling with the internal timer: one interrupt per sixteen operations.
    wr(1'b1, OFS_CON1, 16'h0400);
    wr(1'b1, OFS_CON2, 16'h003c);
    wr(1'b1, OFS_STAT, 16'h0000);
    k = n_dma;
    c0 = n_cv;
    wr(1'b1, OFS_CON1, 16'h94e4);
    while (n_dma == k) @(posedge clk);
    cmp(32'(n_cv - c0), 32'd16);
    cmp(last_wa, 32'h00f);
    wr(1'b1, OFS_STAT, 16'h0000);
    while (n_dma == k + 1) @(posedge clk);
    cmp(32'(n_cv - c0), 32'd32);
    wr(1'b1, OFS_CON1, 16'h0000);
    end_sim();
  end
endmodule : testbench
